// ==== bench/cmd_engine_model.sv ====
// command engine model that finishes each started command after a delay
`timescale 1ns/10ps
module cmd_engine_model
#(
   parameter int busy_cycles = 5
)
(
   input wire logic clk_sys,
   input wire logic command_start,
   output logic cmd_done = 1'b0
);
   int count = 0;
   // slow answer so the code can be read back before it clears
   always @(posedge clk_sys)
   begin
      cmd_done <= #1 (count == 1);
      if (command_start)
         count <= busy_cycles;
      else if (count > 0)
         count <= count - 1;
   end
endmodule : cmd_engine_model

// ==== bench/tb.sv ====
// self-checking bench for the command and bus owner registers
`timescale 1ns/10ps
module tb;
   logic clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, cmd_pins, own_pins, link_pins;
   logic cmd_done, chip_pd, rf_pd, start, running, prim, sec, unlock;
   logic spi, i2c_ls, i2c;
   logic [4:0] code;
   logic [1:0] link;
   int mismatches = 0, n_tests = 0;
   // outputs packed the way the registers read back
   assign cmd_pins = {chip_pd, rf_pd, 1'b0, code};
   assign own_pins = {unlock, prim, sec, 1'b0, link, 2'h0};
   assign link_pins = {5'h00, i2c, i2c_ls, spi};
   always #25 clk_sys = ~clk_sys;
   cmd_owner_regs i_dut (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .cmd_done(cmd_done), .chip_powerdown(chip_pd),
      .rf_frontend_powerdown(rf_pd), .command_code(code),
      .command_start(start), .command_running(running),
      .primary_port_owns_bus(prim), .secure_module_owns_bus(sec),
      .owner_write_unlock(unlock), .secure_module_link_type(link),
      .link_spi_en(spi), .link_i2c_lowspeed_en(i2c_ls),
      .link_i2c_en(i2c));
   cmd_engine_model i_eng (.clk_sys(clk_sys), .command_start(start),
      .cmd_done(cmd_done));
   task automatic check(input string nm, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // idle edge first so back-to-back calls always retoggle the strobe,
   // then one strobe cycle; outputs settle 1 ns after the taking edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk_sys) #1 reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      @(posedge clk_sys) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk_sys) #1 reg_rd = 1'b0;
      check("read data", reg_rdata, exp);
   endtask : rd
   task automatic test_done;
      $display("%0d checks, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (3) @(posedge clk_sys);
      #1 reset = 1'b0;
      rd(cmd_owner_pkg::addr_command, 8'h00);
      rd(cmd_owner_pkg::addr_owner, 8'h00);
      wr(cmd_owner_pkg::addr_command, 8'hFF);
      check("command outputs", cmd_pins, 8'hDF);
      check("command status", 8'({running, start}), 8'h03);
      rd(cmd_owner_pkg::addr_command, 8'hDF);
      repeat (8) @(posedge clk_sys);
      #1 check("command after done", cmd_pins, 8'hC0);
      check("status after done", 8'({running, start}), 8'h00);
      $display("command test done");
      // locked: owners refused, link type and reserved bits as stated
      wr(cmd_owner_pkg::addr_owner, 8'h7F);
      check("locked owner", own_pins, 8'h0C);
      rd(cmd_owner_pkg::addr_owner, 8'h0C);
      for (int k = 0; k < 4; k++)
      begin
         wr(cmd_owner_pkg::addr_owner, 8'(k << 2));
         check("link enables", link_pins, 8'((1 << k) >> 1));
      end
      $display("locked and link test done");
      wr(cmd_owner_pkg::addr_owner, 8'h80);
      check("unlock", own_pins, 8'h80);
      wr(cmd_owner_pkg::addr_owner, 8'h44);
      check("host owner", own_pins, 8'h44);
      wr(cmd_owner_pkg::addr_owner, 8'h80);
      wr(cmd_owner_pkg::addr_owner, 8'h20);
      check("module owner", own_pins, 8'h20);
      wr(cmd_owner_pkg::addr_owner, 8'h80);
      wr(cmd_owner_pkg::addr_owner, 8'h60);
      check("both owners", own_pins, 8'h20);
      wr(cmd_owner_pkg::addr_owner, 8'h80);
      wr(cmd_owner_pkg::addr_command, 8'h00);
      check("command stopped", cmd_pins, 8'h00);
      wr(cmd_owner_pkg::addr_owner, 8'h40);
      check("unlock consumed", own_pins, 8'h20);
      rd(7'h02, 8'h00);
      $display("owner test done");
      test_done();
   end
   // the sequence needs well under 100 cycles
   initial
   begin
      #(400 * 50);
      mismatches++;
      test_done();
   end
endmodule : tb

// ==== hw/cmd_owner_pkg.sv ====
// constants for the command and bus owner control registers
package cmd_owner_pkg;
   localparam logic [6:0] addr_command = 7'h00;
   localparam logic [6:0] addr_owner = 7'h01;
   localparam int bit_standby = 7;
   localparam int bit_rf_frontend_powerdown = 6;
   localparam int cmd_hi = 4;
   localparam int bit_owner_write_unlock = 7;
   localparam int bit_primary_port_owns_bus = 6;
   localparam int bit_secure_module_owns_bus = 5;
   localparam int link_hi = 3;
   localparam int link_lo = 2;
   localparam logic [7:0] command_mask = 8'hDF;
   localparam logic [7:0] owner_mask = 8'hEC;
   localparam logic [7:0] reset_command = 8'h00;
   localparam logic [7:0] reset_owner = 8'h00;
   localparam logic [4:0] cmd_idle = 5'h00;
   typedef enum logic [1:0] {
      link_off = 2'h0,
      link_spi = 2'h1,
      i2c_lowspeed_variant = 2'h2,
      link_i2c = 2'h3
   } link_e;
endpackage : cmd_owner_pkg

// ==== hw/cmd_owner_regs.sv ====
// command and bus owner control register pair
//
// What this block does
// - top command bit enters chip power-down
// - bit six powers down receiver and transmitter
// - low five bits are the command code
// - unlock bit allows the next owner change
// - unlock clears itself on next write
// - primary owner bit gives bus to host
// - secure owner bit gives bus to module
// - both owner bits never one together
// - owner bits set only after unlock
// - bits three to two select link type
`timescale 1ns/10ps
module cmd_owner_regs
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic cmd_done,
   output logic chip_powerdown,
   output logic rf_frontend_powerdown,
   output logic [4:0] command_code,
   output logic command_start,
   output logic command_running,
   output logic primary_port_owns_bus,
   output logic secure_module_owns_bus,
   output logic owner_write_unlock,
   output logic [1:0] secure_module_link_type,
   output logic link_spi_en,
   output logic link_i2c_lowspeed_en,
   output logic link_i2c_en
);
   typedef struct packed {
      logic [7:0] command;
      logic [7:0] owner;
      logic [7:0] rdata;
      logic start;
   } state_s;

   state_s state;
   state_s next_state;
   logic wr_cmd;
   logic wr_own;
   logic [7:0] wmask;
   logic [1:0] own_req;

   assign wr_cmd = reg_wr && reg_addr == cmd_owner_pkg::addr_command;
   assign wr_own = reg_wr && reg_addr == cmd_owner_pkg::addr_owner;
   assign own_req = reg_wdata[cmd_owner_pkg::bit_primary_port_owns_bus -: 2];

   // next state of both registers and the read data
   always_comb
   begin
      next_state = state;
      next_state.start = 1'b0;
      wmask = reg_wdata & cmd_owner_pkg::owner_mask;
      if (wr_cmd)
      begin
         next_state.command = reg_wdata & cmd_owner_pkg::command_mask;
         next_state.start = reg_wdata[cmd_owner_pkg::cmd_hi:0] !=
            cmd_owner_pkg::cmd_idle;
      end
      else if (cmd_done)
         next_state.command[cmd_owner_pkg::cmd_hi:0] = cmd_owner_pkg::cmd_idle;
      // any write consumes the unlock, even to another address
      if (reg_wr && state.owner[cmd_owner_pkg::bit_owner_write_unlock])
         next_state.owner[cmd_owner_pkg::bit_owner_write_unlock] = 1'b0;
      if (wr_own)
      begin
         next_state.owner[cmd_owner_pkg::link_hi:cmd_owner_pkg::link_lo] =
            wmask[cmd_owner_pkg::link_hi:cmd_owner_pkg::link_lo];
         // owner field is protected; a both-ones request is dropped
         if (state.owner[cmd_owner_pkg::bit_owner_write_unlock] &&
             !(&own_req))
            next_state.owner[cmd_owner_pkg::bit_primary_port_owns_bus -: 2] =
               own_req;
         else if (!state.owner[cmd_owner_pkg::bit_owner_write_unlock])
            next_state.owner[cmd_owner_pkg::bit_owner_write_unlock] =
               wmask[cmd_owner_pkg::bit_owner_write_unlock];
      end
      next_state.rdata = 8'h00;
      if (reg_rd)
         case (reg_addr)
            cmd_owner_pkg::addr_command: next_state.rdata = state.command;
            cmd_owner_pkg::addr_owner: next_state.rdata = state.owner;
            default: next_state.rdata = 8'h00;
         endcase
   end

   // single register stage for all state
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state.command <= cmd_owner_pkg::reset_command;
         state.owner <= cmd_owner_pkg::reset_owner;
         state.rdata <= 8'h00;
         state.start <= 1'b0;
      end
      else
         state <= next_state;
   end

   assign reg_rdata = state.rdata;
   assign chip_powerdown = state.command[cmd_owner_pkg::bit_standby];
   assign rf_frontend_powerdown =
      state.command[cmd_owner_pkg::bit_rf_frontend_powerdown];
   assign command_code = state.command[cmd_owner_pkg::cmd_hi:0];
   assign command_start = state.start;
   assign command_running = command_code != cmd_owner_pkg::cmd_idle;
   assign primary_port_owns_bus =
      state.owner[cmd_owner_pkg::bit_primary_port_owns_bus];
   assign secure_module_owns_bus =
      state.owner[cmd_owner_pkg::bit_secure_module_owns_bus];
   assign owner_write_unlock =
      state.owner[cmd_owner_pkg::bit_owner_write_unlock];
   assign secure_module_link_type =
      state.owner[cmd_owner_pkg::link_hi:cmd_owner_pkg::link_lo];

   link_decode u_link
   (
      .secure_module_link_type(secure_module_link_type),
      .link_spi_en(link_spi_en),
      .link_i2c_lowspeed_en(link_i2c_lowspeed_en),
      .link_i2c_en(link_i2c_en)
   );

   // the owner pair is one-hot or empty after every edge
   a_owner_exclusive: assert property (
      @(posedge clk_sys) disable iff (reset)
      !(primary_port_owns_bus && secure_module_owns_bus))
      else $error("both bus owners set");

   // a locked write may touch only the unlock and the link field
   a_owner_locked: assert property (
      @(posedge clk_sys) disable iff (reset)
      (wr_own && !owner_write_unlock) |=>
      $stable({primary_port_owns_bus, secure_module_owns_bus}))
      else $error("owner changed without unlock");

   // owners move only on a write to the owner register
   a_owner_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      !wr_own |=> $stable({primary_port_owns_bus, secure_module_owns_bus}))
      else $error("owner changed with no owner write");

   // an unlocked single-owner request lands as written
   a_owner_taken: assert property (
      @(posedge clk_sys) disable iff (reset)
      (wr_own && owner_write_unlock && !(&own_req)) |=>
      {primary_port_owns_bus, secure_module_owns_bus} == $past(own_req))
      else $error("unlocked owner write not taken");

   // a both-ones request is dropped even when unlocked
   a_owner_both: assert property (
      @(posedge clk_sys) disable iff (reset)
      (wr_own && owner_write_unlock && (&own_req)) |=>
      $stable({primary_port_owns_bus, secure_module_owns_bus}))
      else $error("both-ones owner request taken");

   // unlock arms only from the locked state, never re-arms itself
   a_unlock_arm: assert property (
      @(posedge clk_sys) disable iff (reset)
      (wr_own && !owner_write_unlock) |=> owner_write_unlock ==
      $past(reg_wdata[cmd_owner_pkg::bit_owner_write_unlock]))
      else $error("unlock bit not taken");

   // any write while unlocked spends the unlock
   a_unlock_once: assert property (
      @(posedge clk_sys) disable iff (reset)
      (reg_wr && owner_write_unlock) |=> !owner_write_unlock)
      else $error("unlock survived a write");

   // command field and power bits store what was written
   a_cmd_code: assert property (
      @(posedge clk_sys) disable iff (reset)
      wr_cmd |=>
      command_code == $past(reg_wdata[cmd_owner_pkg::cmd_hi:0]))
      else $error("command code not stored");
   a_standby_bit: assert property (
      @(posedge clk_sys) disable iff (reset)
      wr_cmd |=>
      chip_powerdown == $past(reg_wdata[cmd_owner_pkg::bit_standby]))
      else $error("standby bit wrong");
   a_rf_bit: assert property (
      @(posedge clk_sys) disable iff (reset)
      wr_cmd |=> rf_frontend_powerdown ==
      $past(reg_wdata[cmd_owner_pkg::bit_rf_frontend_powerdown]))
      else $error("rf power-down bit wrong");

   // a nonzero code starts the engine, and only a write can do so
   a_cmd_start: assert property (
      @(posedge clk_sys) disable iff (reset)
      (wr_cmd &&
      reg_wdata[cmd_owner_pkg::cmd_hi:0] != cmd_owner_pkg::cmd_idle) |=>
      command_start)
      else $error("command start pulse missing");
   a_cmd_quiet: assert property (
      @(posedge clk_sys) disable iff (reset)
      !wr_cmd |=> !command_start)
      else $error("command start without a write");

   // the engine's done pulse returns the code to idle unless a command write lands in the same cycle
   a_cmd_done: assert property (
      @(posedge clk_sys) disable iff (reset)
      (cmd_done && !wr_cmd) |=> command_code == cmd_owner_pkg::cmd_idle)
      else $error("done did not clear the code");

   // link field always writable; decode picks at most one link
   a_link_field: assert property (
      @(posedge clk_sys) disable iff (reset)
      wr_own |=> secure_module_link_type ==
      $past(reg_wdata[cmd_owner_pkg::link_hi:cmd_owner_pkg::link_lo]))
      else $error("link type not stored");
   a_link_onehot: assert property (
      @(posedge clk_sys) disable iff (reset)
      $onehot0({link_spi_en, link_i2c_lowspeed_en, link_i2c_en}) &&
      ((secure_module_link_type == cmd_owner_pkg::link_off) ==
      !(link_spi_en || link_i2c_lowspeed_en || link_i2c_en)))
      else $error("link enables not one-hot");

   // reserved positions never read back as one
   a_reserved_zero: assert property (
      @(posedge clk_sys) disable iff (reset)
      (reg_rd && reg_addr == cmd_owner_pkg::addr_owner) |=>
      (reg_rdata & ~cmd_owner_pkg::owner_mask) == 8'h00)
      else $error("reserved bits read nonzero");
   a_cmd_reserved: assert property (
      @(posedge clk_sys) disable iff (reset)
      (reg_rd && reg_addr == cmd_owner_pkg::addr_command) |=>
      (reg_rdata & ~cmd_owner_pkg::command_mask) == 8'h00)
      else $error("reserved command bit read nonzero");
endmodule : cmd_owner_regs

// ==== hw/link_decode.sv ====
// one-hot decode of the secure module link type field
`timescale 1ns/10ps
module link_decode
(
   input wire logic [1:0] secure_module_link_type,
   output logic link_spi_en,
   output logic link_i2c_lowspeed_en,
   output logic link_i2c_en
);
   // field value picks at most one link, zero turns all off
   always_comb
   begin
      link_spi_en = secure_module_link_type == cmd_owner_pkg::link_spi;
      link_i2c_lowspeed_en =
         secure_module_link_type == cmd_owner_pkg::i2c_lowspeed_variant;
      link_i2c_en = secure_module_link_type == cmd_owner_pkg::link_i2c;
   end
endmodule : link_decode
